/* File: pkg/uecs_pkg.sv */
// constants, types and register map of the endpoint control and status block
`default_nettype none
package uecs_pkg;
    localparam int unsigned UECS_NUM_EP = 8;
    // register offsets
    localparam logic [7:0] UECS_OFF_EP_SELECT = 8'hca;
    localparam logic [7:0] UECS_OFF_EP_CSR = 8'hcb;
    localparam logic [7:0] UECS_OFF_EP_BYTE_COUNT = 8'hcc;
    localparam logic [7:0] UECS_OFF_EP_FUNC_CTRL = 8'hcd;
    localparam logic [7:0] UECS_OFF_IRQ_FLAGS = 8'he3;
    localparam logic [7:0] UECS_OFF_IRQ_MASK = 8'he4;
    localparam logic [7:0] UECS_OFF_PROTO_MASK = 8'he2;
    localparam logic [7:0] UECS_OFF_EP_RESET = 8'he5;
    // reset values
    localparam logic [7:0] UECS_RST_BYTE = 8'h00;
    localparam logic [7:0] UECS_RST_PROTO_MASK = 8'h32;
    // control/status field positions
    localparam int unsigned UECS_CSR_TXC = 0;
    localparam int unsigned UECS_CSR_RECEIVED_DATA = 1;
    localparam int unsigned UECS_CSR_SETUP = 2;
    localparam int unsigned UECS_CSR_STALL_SENT = 3;
    localparam int unsigned UECS_CSR_TXBUSY = 4;
    localparam int unsigned UECS_CSR_FORCE_STALL = 5;
    localparam int unsigned UECS_CSR_ISOERR = 6;
    // function control and protocol mask field positions
    localparam int unsigned UECS_FC_ENABLE = 7;
    localparam int unsigned UECS_FC_DIR = 2;
    localparam int unsigned UECS_PM_SUSPEND = 0;

    typedef enum logic [1:0] {
        UECS_TYPE_CONTROL = 2'b00,
        UECS_TYPE_ISO = 2'b01,
        UECS_TYPE_BULK = 2'b10,
        UECS_TYPE_INTR = 2'b11
    } uecs_ep_type_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uecs_reg_req_t;

    // per-endpoint events from the usb engine, endpoint number alongside
    typedef struct packed {
        logic [2:0] ep;
        logic tx_ack;
        logic rx_data;
        logic [7:0] rx_count;
        logic setup;
        logic stall_sent;
        logic iso_crc_valid;
        logic iso_crc_bad;
        logic bank_empty;
    } uecs_usb_evt_t;
endpackage : uecs_pkg
`default_nettype wire

/* File: hdl/uecs_endpoint_ctrl.sv */
// per-endpoint control, status and interrupt logic of the usb device function
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module uecs_endpoint_ctrl #(
    parameter int unsigned NUM_EP = uecs_pkg::UECS_NUM_EP
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire uecs_pkg::uecs_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire uecs_pkg::uecs_usb_evt_t usb_evt,
    input wire logic usb_bus_reset,
    input wire logic suspend_detect,
    input wire logic [2:0] token_ep,
    output logic [NUM_EP-1:0] ep_respond,
    output logic [NUM_EP-1:0] ep_stall,
    output logic [NUM_EP-1:0] ep_tx_ready,
    output logic [NUM_EP-1:0] ep_dir_in,
    output logic [2*NUM_EP-1:0] ep_type,
    output logic [NUM_EP-1:0] ep_data_toggle,
    output logic [NUM_EP-1:0] ep_ptr_clear,
    output logic token_respond,
    output logic token_stall,
    output logic endpoint_irq,
    output logic suspend_irq
);
    import uecs_pkg::*;

    logic [2:0] ep_select_q;
    logic [6:0] csr_q [NUM_EP];
    logic [7:0] byte_count_q [NUM_EP];
    logic [NUM_EP-1:0] endpoint_enable_q;
    logic [NUM_EP-1:0] endpoint_direction_q;
    logic [1:0] endpoint_type_q [NUM_EP];
    logic [NUM_EP-1:0] endpoint_irq_mask_q;
    logic [7:0] proto_mask_q;
    logic suspend_pend_q;
    logic [NUM_EP-1:0] endpoint_reset_q;
    logic [NUM_EP-1:0] toggle_q;
    logic [NUM_EP-1:0] endpoint_irq_flag;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    // decoding of a write to an indexed register, used by several processes
    function automatic logic idx_write(input uecs_reg_req_t r, input logic [7:0] off,
                                       input logic [2:0] sel, input int unsigned n);
        idx_write = r.wr && (r.addr == off) && (sel == 3'(n));
    endfunction

    // plain register write decode, shared by the global registers
    function automatic logic reg_write(input uecs_reg_req_t r, input logic [7:0] off);
        reg_write = r.wr && (r.addr == off);
    endfunction

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ep_select_q <= 3'h0;
        end else if (reg_write(reg_req, UECS_OFF_EP_SELECT)) begin
            ep_select_q <= reg_req.wdata[2:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            endpoint_irq_mask_q <= '0;
        end else if (reg_write(reg_req, UECS_OFF_IRQ_MASK)) begin
            endpoint_irq_mask_q <= reg_req.wdata[NUM_EP-1:0];
        end
    end

    // protocol mask: only the low four bits are kept, the rest read zero once written
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            proto_mask_q <= UECS_RST_PROTO_MASK;
        end else if (reg_write(reg_req, UECS_OFF_PROTO_MASK)) begin
            proto_mask_q <= {4'h0, reg_req.wdata[3:0]};
        end
    end

    // suspend pending is held until software rewrites the mask register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            suspend_pend_q <= 1'b0;
        end else if (suspend_detect) begin
            suspend_pend_q <= 1'b1;
        end else if (reg_write(reg_req, UECS_OFF_PROTO_MASK)) begin
            suspend_pend_q <= 1'b0;
        end
    end

    assign suspend_irq = suspend_pend_q & proto_mask_q[UECS_PM_SUSPEND];

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            logic hit;
            logic is_ctrl;
            logic dir_in;
            logic wr_csr;
            logic wr_fc;
            logic [6:0] sw;
            logic src_txc;
            logic src_received_data;
            logic src_setup;
            logic src_stall;
            assign hit = (usb_evt.ep == 3'(g));
            assign is_ctrl = (endpoint_type_q[g] == UECS_TYPE_CONTROL);
            assign wr_csr = idx_write(reg_req, UECS_OFF_EP_CSR, ep_select_q, g);
            assign wr_fc = idx_write(reg_req, UECS_OFF_EP_FUNC_CTRL, ep_select_q, g);
            assign sw = reg_req.wdata[6:0];
            assign dir_in = endpoint_direction_q[g] | is_ctrl;

            // status bits: hardware set wins over a software clear in the same cycle,
            // so an event arriving while software acknowledges is never lost
            // ack sets transmit complete
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    csr_q[g][UECS_CSR_TXC] <= 1'b0;
                end else if (hit && usb_evt.tx_ack) begin
                    csr_q[g][UECS_CSR_TXC] <= 1'b1;
                end else if (wr_csr && !sw[UECS_CSR_TXC]) begin
                    csr_q[g][UECS_CSR_TXC] <= 1'b0;
                end
            end

            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    csr_q[g][UECS_CSR_RECEIVED_DATA] <= 1'b0;
                end else if (hit && usb_evt.rx_data) begin
                    csr_q[g][UECS_CSR_RECEIVED_DATA] <= 1'b1;
                end else if (wr_csr && !sw[UECS_CSR_RECEIVED_DATA]) begin
                    csr_q[g][UECS_CSR_RECEIVED_DATA] <= 1'b0;
                end
            end

            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    csr_q[g][UECS_CSR_SETUP] <= 1'b0;
                end else if (hit && usb_evt.setup && is_ctrl) begin
                    csr_q[g][UECS_CSR_SETUP] <= 1'b1;
                end else if (wr_csr && !sw[UECS_CSR_SETUP]) begin
                    csr_q[g][UECS_CSR_SETUP] <= 1'b0;
                end
            end

            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    csr_q[g][UECS_CSR_STALL_SENT] <= 1'b0;
                end else if (hit && usb_evt.stall_sent) begin
                    csr_q[g][UECS_CSR_STALL_SENT] <= 1'b1;
                end else if (wr_csr && !sw[UECS_CSR_STALL_SENT]) begin
                    csr_q[g][UECS_CSR_STALL_SENT] <= 1'b0;
                end
            end

            // software sets busy, bank empty clears it
            // a refill in the cycle the bank drains keeps the bank busy
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    csr_q[g][UECS_CSR_TXBUSY] <= 1'b0;
                end else if (wr_csr && sw[UECS_CSR_TXBUSY]) begin
                    csr_q[g][UECS_CSR_TXBUSY] <= 1'b1;
                end else if (hit && usb_evt.bank_empty) begin
                    csr_q[g][UECS_CSR_TXBUSY] <= 1'b0;
                end
            end

            // force stall is a plain control bit
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    csr_q[g][UECS_CSR_FORCE_STALL] <= 1'b0;
                end else if (wr_csr) begin
                    csr_q[g][UECS_CSR_FORCE_STALL] <= sw[UECS_CSR_FORCE_STALL];
                end
            end

            // crc result of iso packet, read-only to software
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    csr_q[g][UECS_CSR_ISOERR] <= 1'b0;
                end else if (hit && usb_evt.iso_crc_valid
                             && endpoint_type_q[g] == UECS_TYPE_ISO) begin
                    csr_q[g][UECS_CSR_ISOERR] <= usb_evt.iso_crc_bad;
                end
            end

            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    byte_count_q[g] <= UECS_RST_BYTE;
                end else if (hit && usb_evt.rx_data) begin
                    byte_count_q[g] <= usb_evt.rx_count;
                end
            end

            // bus reset enables endpoint zero, over a same-cycle write
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    endpoint_enable_q[g] <= 1'b0;
                end else if (usb_bus_reset && g == 0) begin
                    endpoint_enable_q[g] <= 1'b1;
                end else if (wr_fc) begin
                    endpoint_enable_q[g] <= reg_req.wdata[UECS_FC_ENABLE];
                end
            end

            // endpoint direction
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    endpoint_direction_q[g] <= 1'b0;
                end else if (wr_fc) begin
                    endpoint_direction_q[g] <= reg_req.wdata[UECS_FC_DIR];
                end
            end

            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    endpoint_type_q[g] <= UECS_TYPE_CONTROL;
                end else if (wr_fc) begin
                    endpoint_type_q[g] <= reg_req.wdata[1:0];
                end
            end

            // endpoint reset, self-clearing after one cycle
            // a write while the bit is still up is ignored, so one request is one pulse
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    endpoint_reset_q[g] <= 1'b0;
                end else if (reg_write(reg_req, UECS_OFF_EP_RESET) && !endpoint_reset_q[g]) begin
                    endpoint_reset_q[g] <= reg_req.wdata[g];
                end else begin
                    endpoint_reset_q[g] <= 1'b0;
                end
            end

            // data toggle: endpoint reset forces zero ahead of any event
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    toggle_q[g] <= 1'b0;
                end else if (endpoint_reset_q[g]) begin
                    toggle_q[g] <= 1'b0;
                end else if (hit && (usb_evt.tx_ack || usb_evt.rx_data)) begin
                    toggle_q[g] <= ~toggle_q[g];
                end
            end

            // sources qualified by type and direction
            assign src_txc = csr_q[g][UECS_CSR_TXC] && dir_in
                             && endpoint_type_q[g] != UECS_TYPE_ISO;
            assign src_received_data = csr_q[g][UECS_CSR_RECEIVED_DATA] && !(endpoint_direction_q[g] && !is_ctrl);
            assign src_setup = csr_q[g][UECS_CSR_SETUP] && is_ctrl;
            assign src_stall = csr_q[g][UECS_CSR_STALL_SENT] && endpoint_type_q[g] != UECS_TYPE_ISO;
            // any qualified source raises the flag
            // flag falls when sources are cleared
            assign endpoint_irq_flag[g] = src_txc | src_received_data | src_setup | src_stall;

            assign ep_respond[g] = endpoint_enable_q[g];
            assign ep_stall[g] = endpoint_enable_q[g] & csr_q[g][UECS_CSR_FORCE_STALL];
            assign ep_tx_ready[g] = csr_q[g][UECS_CSR_TXBUSY];
            assign ep_dir_in[g] = dir_in;
            assign ep_type[2*g +: 2] = endpoint_type_q[g];
            assign ep_data_toggle[g] = toggle_q[g];
            assign ep_ptr_clear[g] = endpoint_reset_q[g];
        end
    endgenerate

    // token lookup is combinational so the answer is ready in the token's own cycle
    assign token_respond = ep_respond[token_ep];
    assign token_stall = ep_stall[token_ep];

    assign endpoint_irq = |(endpoint_irq_flag & endpoint_irq_mask_q);

    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_req.addr)
            UECS_OFF_EP_SELECT: rdata_d = {5'h00, ep_select_q};
            UECS_OFF_EP_CSR: rdata_d = {1'b0, csr_q[ep_select_q]};
            UECS_OFF_EP_BYTE_COUNT: rdata_d = byte_count_q[ep_select_q];
            UECS_OFF_EP_FUNC_CTRL: rdata_d = {endpoint_enable_q[ep_select_q], 4'h0,
                                              endpoint_direction_q[ep_select_q],
                                              endpoint_type_q[ep_select_q]};
            UECS_OFF_IRQ_FLAGS: rdata_d = 8'(endpoint_irq_flag);
            UECS_OFF_IRQ_MASK: rdata_d = 8'(endpoint_irq_mask_q);
            UECS_OFF_PROTO_MASK: rdata_d = proto_mask_q;
            UECS_OFF_EP_RESET: rdata_d = 8'(endpoint_reset_q);
            default: rdata_d = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else if (reg_req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;
endmodule : uecs_endpoint_ctrl
`default_nettype wire

/* File: bench/uecs_endpoint_ctrl_asserts.sv */
// port-level assertions for the endpoint control and status block
`timescale 1ns/1ps
`default_nettype none
module uecs_endpoint_ctrl_asserts #(
    parameter int unsigned NUM_EP = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire uecs_pkg::uecs_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire uecs_pkg::uecs_usb_evt_t usb_evt,
    input wire logic usb_bus_reset,
    input wire logic suspend_detect,
    input wire logic [2:0] token_ep,
    input wire logic [NUM_EP-1:0] ep_respond,
    input wire logic [NUM_EP-1:0] ep_stall,
    input wire logic [NUM_EP-1:0] ep_tx_ready,
    input wire logic [NUM_EP-1:0] ep_dir_in,
    input wire logic [2*NUM_EP-1:0] ep_type,
    input wire logic [NUM_EP-1:0] ep_ptr_clear,
    input wire logic token_respond,
    input wire logic token_stall,
    input wire logic endpoint_irq,
    input wire logic suspend_irq
);
    import uecs_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // endpoint chosen by software, tracked from the register port
    logic [2:0] sel_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sel_q <= 3'h0;
        end else if (reg_req.wr && reg_req.addr == UECS_OFF_EP_SELECT) begin
            sel_q <= reg_req.wdata[2:0];
        end
    end
    property p_rdata_idle; !$past(reg_req.rd) |-> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_irq_cause;
        $rose(endpoint_irq) |-> $past(usb_evt.tx_ack | usb_evt.rx_data | usb_evt.setup
            | usb_evt.stall_sent) || $past(reg_req.wr && reg_req.addr == UECS_OFF_IRQ_MASK);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
    property p_busy;
        reg_req.wr && reg_req.addr == UECS_OFF_EP_CSR && reg_req.wdata[UECS_CSR_TXBUSY]
            |=> ep_tx_ready != 0;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not set");
    property p_bus_reset; usb_bus_reset |=> ep_respond[0]; endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("ep0 not enabled");
    property p_tok_stall;
        reg_req.wr && reg_req.addr == UECS_OFF_EP_CSR && ep_respond[sel_q]
            |=> ep_stall[$past(sel_q)] == $past(reg_req.wdata[UECS_CSR_FORCE_STALL]);
    endproperty
    a_tok_stall: assert property (p_tok_stall) else $error("stall answer wrong");
    property p_tok_resp;
        reg_req.wr && reg_req.addr == UECS_OFF_EP_FUNC_CTRL && !usb_bus_reset
            |=> ep_respond[$past(sel_q)] == $past(reg_req.wdata[UECS_FC_ENABLE]);
    endproperty
    a_tok_resp: assert property (p_tok_resp) else $error("respond wrong");
    property p_ctl_dir; ep_type[2*token_ep +: 2] == 2'b00 |-> ep_dir_in[token_ep]; endproperty
    a_ctl_dir: assert property (p_ctl_dir) else $error("control dir not both");
    property p_ptr_clear;
        reg_req.wr && reg_req.addr == UECS_OFF_EP_RESET && reg_req.wdata != 0
            |-> ##[1:2] ep_ptr_clear != 0;
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("no pointer clear");
    property p_suspend;
        $rose(suspend_irq) |-> $past(suspend_detect)
            || $past(reg_req.wr && reg_req.addr == UECS_OFF_PROTO_MASK);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend irq uncaused");
endmodule // uecs_endpoint_ctrl_asserts
bind uecs_endpoint_ctrl uecs_endpoint_ctrl_asserts #(.NUM_EP(NUM_EP)) u_chk (
    .mclk(mclk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .usb_evt(usb_evt), .usb_bus_reset(usb_bus_reset), .suspend_detect(suspend_detect),
    .token_ep(token_ep), .ep_respond(ep_respond), .ep_stall(ep_stall),
    .ep_tx_ready(ep_tx_ready), .ep_dir_in(ep_dir_in), .ep_type(ep_type),
    .ep_ptr_clear(ep_ptr_clear), .token_respond(token_respond), .token_stall(token_stall),
    .endpoint_irq(endpoint_irq), .suspend_irq(suspend_irq)
);
`default_nettype wire

/* File: bench/uecs_host_model.sv */
// behavioural usb host side: event pulses, tokens, bus reset and suspend
`timescale 1ns/1ps
`default_nettype none
module uecs_host_model (
    input wire logic mclk,
    output var uecs_pkg::uecs_usb_evt_t usb_evt,
    output var logic usb_bus_reset,
    output var logic suspend_detect,
    output var logic [2:0] token_ep
);
    import uecs_pkg::*;
    initial begin
        usb_evt = '0;
        usb_bus_reset = 1'b0;
        suspend_detect = 1'b0;
        token_ep = 3'h0;
    end
    // kind: 0 ack, 1 data, 2 setup, 3 stall sent, 4 good iso, 5 bad iso, 6 empty, 7 suspend, 8 reset
    task automatic ev(input logic [2:0] ep, input int kind, input logic [7:0] cnt);
        uecs_usb_evt_t v;
        v = '0;
        v.ep = ep;
        v.rx_count = cnt;
        v.tx_ack = kind == 0;
        v.rx_data = kind == 1;
        v.setup = kind == 2;
        v.stall_sent = kind == 3;
        v.iso_crc_valid = kind == 4 || kind == 5;
        v.iso_crc_bad = kind == 5;
        v.bank_empty = kind == 6;
        @(posedge mclk);
        usb_evt <= v;
        suspend_detect <= kind == 7;
        usb_bus_reset <= kind == 8;
        @(posedge mclk);
        // released lines carry no stale endpoint or count
        v = '0;
        v.ep = ~ep;
        v.rx_count = ~cnt;
        usb_evt <= v;
        suspend_detect <= 1'b0;
        usb_bus_reset <= 1'b0;
    endtask
    task automatic tok(input logic [2:0] ep);
        @(posedge mclk);
        token_ep <= ep;
    endtask
endmodule // uecs_host_model
`default_nettype wire

/* File: bench/uecs_endpoint_ctrl_bench.sv */
// self-checking bench for the endpoint control and status block
`timescale 1ns/1ps
`default_nettype none
module uecs_endpoint_ctrl_bench;
    import uecs_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    uecs_reg_req_t req = '0;
    uecs_usb_evt_t evt;
    logic brst, sus, trsp, tstl, eirq, sirq;
    logic rd_p = 1'b0;
    logic [2:0] tep;
    logic [7:0] rdata, respond, stall, txr, dirin, tog, ptrc;
    logic [15:0] typ;
    int errors = 0;
    int compares = 0;
    logic [7:0] expq[$];
    logic [7:0] adr[8] = '{8'hca, 8'hcb, 8'hcc, 8'hcd, 8'he3, 8'he4, 8'he2, 8'h10};
    logic [31:0] evt_tab[8] = '{32'h0002_0401, 32'h0000_0101, 32'h0003_0801, 32'h0300_0108,
        32'h0302_0000, 32'h0101_0202, 32'h0105_4000, 32'h0104_0000};
    always #25 mclk = ~mclk;
    uecs_endpoint_ctrl #(.NUM_EP(8)) u_dut (.mclk(mclk), .reset_n(reset_n), .reg_req(req),
        .reg_rdata(rdata), .usb_evt(evt), .usb_bus_reset(brst), .suspend_detect(sus),
        .token_ep(tep), .ep_respond(respond), .ep_stall(stall), .ep_tx_ready(txr),
        .ep_dir_in(dirin), .ep_type(typ), .ep_data_toggle(tog), .ep_ptr_clear(ptrc),
        .token_respond(trsp), .token_stall(tstl), .endpoint_irq(eirq), .suspend_irq(sirq));
    uecs_host_model u_host (.mclk(mclk), .usb_evt(evt), .usb_bus_reset(brst),
        .suspend_detect(sus), .token_ep(tep));
    task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask
    // expected data is queued as the read is issued
    task reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        expq.push_back(e);
        @(posedge mclk);
        req.rd <= 1'b0;
    endtask
    always @(posedge mclk) rd_p <= req.rd;
    always @(negedge mclk) begin
        if (rd_p) begin
            chk8("reg_rdata", expq.pop_front(), rdata);
        end
    end
    task report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] c;
        logic d;
        logic [31:0] t;
        void'($urandom(32'h698447b6));
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (adr[i]) reg_rd(adr[i], adr[i] == 8'he2 ? UECS_RST_PROTO_MASK : UECS_RST_BYTE);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            d = (i < 4) ? (i == 3) : 1'($urandom);
            reg_wr(UECS_OFF_EP_SELECT, 8'hf8 | 8'(i));
            reg_rd(UECS_OFF_EP_SELECT, 8'(i));
            reg_wr(UECS_OFF_EP_FUNC_CTRL, {5'h1f, d, 2'(i)});
            reg_rd(UECS_OFF_EP_FUNC_CTRL, {5'h10, d, 2'(i)});
            @(negedge mclk);
            chk8("ep_type", 8'(i % 4), 8'(typ[2*i +: 2]));
            chk8("ep_dir_in", 8'(d | (i % 4 == 0)), 8'(dirin[i]));
        end
        chk8("ep_respond", 8'hff, respond);
        $display("endpoint setup done");
        c = 8'($urandom);
        u_host.ev(3'h2, 1, c);
        reg_wr(UECS_OFF_EP_SELECT, 8'h02);
        reg_rd(UECS_OFF_EP_CSR, 8'h02);
        reg_rd(UECS_OFF_EP_BYTE_COUNT, c);
        reg_rd(UECS_OFF_IRQ_FLAGS, 8'h04);
        reg_wr(UECS_OFF_IRQ_MASK, 8'hfb);
        @(negedge mclk);
        chk8("endpoint_irq", 8'h00, 8'(eirq));
        reg_wr(UECS_OFF_IRQ_MASK, 8'h04);
        @(negedge mclk);
        chk8("endpoint_irq", 8'h01, 8'(eirq));
        reg_wr(UECS_OFF_IRQ_FLAGS, 8'h00);
        reg_rd(UECS_OFF_IRQ_FLAGS, 8'h04);
        reg_wr(UECS_OFF_EP_CSR, 8'h0d);
        reg_rd(UECS_OFF_IRQ_FLAGS, 8'h00);
        chk8("ep_data_toggle", 8'h04, tog & 8'h04);
        $display("receive done");
        reg_wr(UECS_OFF_IRQ_MASK, 8'hff);
        foreach (evt_tab[k]) begin
            t = evt_tab[k];
            u_host.ev(t[26:24], int'(t[23:16]), 8'h00);
            reg_wr(UECS_OFF_EP_SELECT, t[31:24]);
            reg_rd(UECS_OFF_EP_CSR, t[15:8]);
            reg_rd(UECS_OFF_IRQ_FLAGS, t[7:0]);
            reg_wr(UECS_OFF_EP_CSR, 8'h00);
            reg_rd(UECS_OFF_IRQ_FLAGS, 8'h00);
        end
        $display("event table done");
        reg_wr(UECS_OFF_EP_SELECT, 8'h03);
        reg_wr(UECS_OFF_EP_CSR, 8'h30);
        u_host.tok(3'h3);
        @(negedge mclk);
        chk8("token_stall", 8'h01, 8'(tstl));
        chk8("ep_tx_ready", 8'h08, txr);
        reg_rd(UECS_OFF_IRQ_FLAGS, 8'h00);
        u_host.ev(3'h3, 6, 8'h00);
        reg_rd(UECS_OFF_EP_CSR, 8'h20);
        reg_wr(UECS_OFF_EP_CSR, 8'h00);
        $display("stall and busy done");
        reg_wr(UECS_OFF_EP_SELECT, 8'h00);
        reg_wr(UECS_OFF_EP_FUNC_CTRL, 8'h00);
        u_host.tok(3'h0);
        @(negedge mclk);
        chk8("token_respond", 8'h00, 8'(trsp));
        u_host.ev(3'h0, 8, 8'h00);
        reg_rd(UECS_OFF_EP_FUNC_CTRL, 8'h80);
        reg_wr(UECS_OFF_EP_RESET, 8'h04);
        @(negedge mclk);
        chk8("ep_ptr_clear", 8'h04, ptrc);
        @(negedge mclk);
        chk8("ep_data_toggle", 8'h00, tog & 8'h04);
        reg_rd(UECS_OFF_EP_RESET, 8'h00);
        $display("bus and endpoint reset done");
        reg_wr(UECS_OFF_PROTO_MASK, 8'h00);
        u_host.ev(3'h0, 7, 8'h00);
        @(negedge mclk);
        chk8("suspend_irq", 8'h00, 8'(sirq));
        reg_wr(UECS_OFF_PROTO_MASK, 8'h01);
        u_host.ev(3'h0, 7, 8'h00);
        @(negedge mclk);
        chk8("suspend_irq", 8'h01, 8'(sirq));
        $display("suspend mask done");
        repeat (2) @(posedge mclk);
        report_and_stop();
    end
    // about 250 cycles of tests; the limit leaves wide headroom
    initial begin
        #200us;
        errors++;
        report_and_stop();
    end
endmodule // uecs_endpoint_ctrl_bench
`default_nettype wire
